// file: inc/type_range_pkg.sv
`default_nettype none
package type_range_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int PHYS_ADDR_WIDTH = 36;
    localparam int FIELD_LSB = 12;
    localparam int MASK_WIDTH = PHYS_ADDR_WIDTH - FIELD_LSB;
    localparam int REG_W = 64;
    localparam int TYPE_W = 8;
    localparam int NUM_FIXED = 11;
    localparam int NUM_VAR = 8;
    localparam int FIELDS_PER_REG = 8;
    localparam int INDEX_W = 6;

    // ************************************************************
    // Memory type encodings
    // ************************************************************
    localparam logic [7:0] TYPE_UNCACHED = 8'h00;
    localparam logic [7:0] TYPE_WRITE_COMBINE = 8'h01;
    localparam logic [7:0] TYPE_WRITE_THROUGH = 8'h04;
    localparam logic [7:0] TYPE_WRITE_PROTECT = 8'h05;
    localparam logic [7:0] TYPE_WRITE_BACK = 8'h06;

    // ************************************************************
    // Field positions and reserved-bit masks
    // ************************************************************
    localparam int FIXED_ON_BIT = 10;
    localparam int GLOBAL_EN_BIT = 11;
    localparam int VALID_BIT = 11;
    localparam logic [63:0] DEF_RSVD = 64'hffff_ffff_ffff_f300;
    localparam logic [63:0] BASE_RSVD = 64'hffff_fff0_0000_0f00;
    localparam logic [63:0] MASK_RSVD = 64'hffff_fff0_0000_07ff;
    localparam logic [63:0] RESET_VALUE = 64'h0000_0000_0000_0000;
    localparam logic [11:0] LOW_ZEROS = 12'h000;

    // ************************************************************
    // Register indices on the register port
    // ************************************************************
    localparam logic [5:0] IDX_DEF = 6'h00;
    localparam logic [5:0] IDX_FIX_FIRST = 6'h01;
    localparam logic [5:0] IDX_FIX_LAST = 6'h0b;
    localparam logic [5:0] IDX_VAR_FIRST = 6'h10;
    localparam logic [5:0] IDX_VAR_LAST = 6'h1f;

    // ************************************************************
    // Fixed-range address map
    // ************************************************************
    localparam logic [35:0] FIX64_END = 36'h0_0008_0000;
    localparam logic [35:0] FIX16_END = 36'h0_000c_0000;
    localparam logic [35:0] FIX_END = 36'h0_0010_0000;
    localparam int SUB64_LSB = 16;
    localparam int SUB16_LSB = 14;
    localparam int SUB4_LSB = 12;
    localparam logic [3:0] SLOT_64K = 4'h0;
    localparam logic [3:0] SLOT_16K = 4'h1;
    localparam logic [3:0] SLOT_4K = 4'h3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [INDEX_W-1:0] index;
        logic [REG_W-1:0] data;
    } reg_req_t;

    typedef struct packed {
        logic rd_valid;
        logic [REG_W-1:0] rd_data;
        logic fault;
    } reg_rsp_t;

    typedef struct packed {
        logic valid;
        logic [PHYS_ADDR_WIDTH-1:0] addr;
    } lookup_req_t;

    typedef struct packed {
        logic valid;
        logic [TYPE_W-1:0] mem_type;
    } lookup_rsp_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic legal_type(input logic [7:0] t);
        legal_type = (t == TYPE_UNCACHED) || (t == TYPE_WRITE_COMBINE)
            || (t == TYPE_WRITE_THROUGH) || (t == TYPE_WRITE_PROTECT)
            || (t == TYPE_WRITE_BACK);
    endfunction

    function automatic logic all_types_legal(input logic [63:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < FIELDS_PER_REG; i++) begin
            ok = ok & legal_type(v[i*TYPE_W +: TYPE_W]);
        end
        all_types_legal = ok;
    endfunction

endpackage
`default_nettype wire

// file: hw/var_range_match.sv
`timescale 1ns/1ps
`default_nettype none
module var_range_match (
    // Address under lookup
    input wire logic [type_range_pkg::PHYS_ADDR_WIDTH-1:0] addr,
    // One register pair
    input wire logic [type_range_pkg::REG_W-1:0] base_reg,
    input wire logic [type_range_pkg::REG_W-1:0] mask_reg,
    // Match answer
    output logic hit,
    output logic [type_range_pkg::TYPE_W-1:0] range_type
);
    localparam int AW = type_range_pkg::PHYS_ADDR_WIDTH;
    localparam int LSB = type_range_pkg::FIELD_LSB;

    // Base and mask widened by twelve low zeros, so ranges sit on 4 KB
    wire logic [AW-1:0] ext_base = {base_reg[AW-1:LSB], type_range_pkg::LOW_ZEROS};
    wire logic [AW-1:0] ext_mask = {mask_reg[AW-1:LSB], type_range_pkg::LOW_ZEROS};

    // Masked compare; gaps in a mask simply fall through to the default
    assign hit = mask_reg[type_range_pkg::VALID_BIT]
        && ((addr & ext_mask) == (ext_base & ext_mask));
    assign range_type = base_reg[type_range_pkg::TYPE_W-1:0];
endmodule // var_range_match
`default_nettype wire

// file: hw/type_range_register_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Unmapped addresses return the default type field while globally enabled.
// - Default type accepts only 0,1,4,5,6; other writes fault, not stored.
// - Fixed-enable bit 10 switches all fixed-range registers on or off.
// - Fixed sub-range type wins over any variable range when enabled.
// - With fixed ranges off, variable ranges also cover the first megabyte.
// - Global enable bit 11 clear makes every address uncached.
// - Fixed-enable has no effect while the global enable is clear.
// - Enabled, addresses outside fixed and valid variable ranges take default type.
// - Nonzero writes to default bits 8, 9, 12..63 fault.
// - Eleven 64-bit fixed registers, each eight 8-bit type fields.
// - 0..7FFFF mapped by one register, one field per 64 KB.
// - 80000..BFFFF mapped by two registers, one field per 16 KB.
// - C0000..FFFFF mapped by eight registers, one field per 4 KB.
// - Eight variable ranges, each a base/type and mask register pair.
// - Matched variable range type comes from base register low byte.
// - Base gets twelve low zero bits, forcing 4 KB alignment.
// - Mask field is address width minus twelve, widened by low zeros.
// - Address matches when address AND mask equals base AND mask.
// - A pair matches only while its mask valid bit 11 is set.
// - Writes to reserved bits of base or mask registers fault.
// - Addresses a gapped mask leaves out get the default type.
// - 36-bit addresses: 24-bit mask, upper 28 mask bits reserved.
// - Types uncached 00, combine 01, through 04, protect 05, back 06; others fault.
// - Multiple hits: common type, else uncached if any, through for through/back.
// - Reset clears variable valid flags and the global enable.
module type_range_register_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire type_range_pkg::reg_req_t reg_req,
    output type_range_pkg::reg_rsp_t reg_rsp,
    // Memory type lookup
    input wire type_range_pkg::lookup_req_t lookup_req,
    output type_range_pkg::lookup_rsp_t lookup_rsp
);
    localparam int AW = type_range_pkg::PHYS_ADDR_WIDTH;
    localparam int TW = type_range_pkg::TYPE_W;
    localparam int RW = type_range_pkg::REG_W;
    localparam int NV = type_range_pkg::NUM_VAR;
    localparam int NF = type_range_pkg::NUM_FIXED;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [RW-1:0] default_type_control;
    logic [RW-1:0] fixed_types [NF];
    logic [RW-1:0] variable_range_base [NV];
    logic [RW-1:0] variable_range_mask [NV];

    // ************************************************************
    // Register write decode
    // ************************************************************
    wire logic [5:0] idx = reg_req.index;
    wire logic is_def = (idx == type_range_pkg::IDX_DEF);
    wire logic is_fix = (idx >= type_range_pkg::IDX_FIX_FIRST)
        && (idx <= type_range_pkg::IDX_FIX_LAST);
    wire logic is_var = (idx >= type_range_pkg::IDX_VAR_FIRST)
        && (idx <= type_range_pkg::IDX_VAR_LAST);
    wire logic mapped = is_def || is_fix || is_var;
    wire logic [5:0] fix_off = idx - type_range_pkg::IDX_FIX_FIRST;
    wire logic [3:0] fix_slot = fix_off[3:0];
    wire logic [2:0] var_slot = idx[3:1];
    wire logic var_is_mask = idx[0];
    wire logic [RW-1:0] wdata = reg_req.data;

    // Per-register write checks
    wire logic def_bad = !type_range_pkg::legal_type(wdata[TW-1:0])
        || ((wdata & type_range_pkg::DEF_RSVD) != '0);
    wire logic fix_bad = !type_range_pkg::all_types_legal(wdata);
    wire logic base_bad = !type_range_pkg::legal_type(wdata[TW-1:0])
        || ((wdata & type_range_pkg::BASE_RSVD) != '0);
    wire logic mask_bad = ((wdata & type_range_pkg::MASK_RSVD) != '0);
    wire logic var_bad = var_is_mask ? mask_bad : base_bad;
    wire logic wr_bad = is_def ? def_bad : is_fix ? fix_bad : is_var ? var_bad : 1'b1;
    wire logic wr_ok = reg_req.wr && !wr_bad;

    // Faulted writes are dropped whole, never partly stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Everything cleared, which covers valid flags and global enable
            default_type_control <= type_range_pkg::RESET_VALUE;
            for (int i = 0; i < NF; i++) begin
                fixed_types[i] <= type_range_pkg::RESET_VALUE;
            end
            for (int i = 0; i < NV; i++) begin
                variable_range_base[i] <= type_range_pkg::RESET_VALUE;
                variable_range_mask[i] <= type_range_pkg::RESET_VALUE;
            end
        end else if (wr_ok) begin
            if (is_def) begin
                default_type_control <= wdata;
            end
            if (is_fix) begin
                fixed_types[fix_slot] <= wdata;
            end
            if (is_var && !var_is_mask) begin
                variable_range_base[var_slot] <= wdata;
            end
            if (is_var && var_is_mask) begin
                variable_range_mask[var_slot] <= wdata;
            end
        end
    end

    // ************************************************************
    // Register read and fault answer
    // ************************************************************
    logic [RW-1:0] rd_sel;
    always_comb begin
        rd_sel = '0;
        if (is_def) begin
            rd_sel = default_type_control;
        end else if (is_fix) begin
            rd_sel = fixed_types[fix_slot];
        end else if (is_var && var_is_mask) begin
            rd_sel = variable_range_mask[var_slot];
        end else if (is_var) begin
            rd_sel = variable_range_base[var_slot];
        end
    end

    wire logic next_fault = (reg_req.wr && wr_bad) || (reg_req.rd && !mapped);
    logic rd_valid;
    logic [RW-1:0] rd_data;
    logic fault;

    // Read data and fault land one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= type_range_pkg::RESET_VALUE;
            fault <= 1'b0;
        end else begin
            rd_valid <= reg_req.rd;
            rd_data <= rd_sel;
            fault <= next_fault;
        end
    end
    assign reg_rsp = '{rd_valid: rd_valid, rd_data: rd_data, fault: fault};

    // ************************************************************
    // Fixed-range lookup
    // ************************************************************
    wire logic [AW-1:0] addr = lookup_req.addr;
    wire logic global_en = default_type_control[type_range_pkg::GLOBAL_EN_BIT];
    wire logic fixed_on = default_type_control[type_range_pkg::FIXED_ON_BIT];
    wire logic [TW-1:0] def_type = default_type_control[TW-1:0];
    wire logic in_first_mb = (addr < type_range_pkg::FIX_END);
    wire logic in_64k = (addr < type_range_pkg::FIX64_END);
    wire logic in_16k = !in_64k && (addr < type_range_pkg::FIX16_END);

    // Register and byte select; low byte always maps the lowest sub-range
    wire logic [3:0] slot_16k = type_range_pkg::SLOT_16K
        + {3'h0, addr[type_range_pkg::SUB16_LSB + 3]};
    wire logic [3:0] slot_4k = type_range_pkg::SLOT_4K
        + {1'h0, addr[type_range_pkg::SUB4_LSB + 3 +: 3]};
    wire logic [3:0] lk_slot = in_64k ? type_range_pkg::SLOT_64K
        : in_16k ? slot_16k : slot_4k;
    wire logic [2:0] lk_field = in_64k ? addr[type_range_pkg::SUB64_LSB +: 3]
        : in_16k ? addr[type_range_pkg::SUB16_LSB +: 3]
        : addr[type_range_pkg::SUB4_LSB +: 3];
    wire logic [RW-1:0] lk_reg = fixed_types[lk_slot];
    wire logic [TW-1:0] fixed_type = lk_reg[{lk_field, 3'h0} +: TW];
    wire logic fixed_hit = fixed_on && in_first_mb;

    // ************************************************************
    // Variable-range lookup
    // ************************************************************
    logic [NV-1:0] var_hit;
    logic [TW-1:0] var_type [NV];
    for (genvar g = 0; g < NV; g++) begin : g_var
        var_range_match u_match (
            .addr(addr),
            .base_reg(variable_range_base[g]),
            .mask_reg(variable_range_mask[g]),
            .hit(var_hit[g]),
            .range_type(var_type[g])
        );
    end

    // Overlap merge by AND/OR of hit types; undefined mixes fall to uncached
    logic [TW-1:0] and_t;
    logic [TW-1:0] or_t;
    logic [TW-1:0] merged_type;
    always_comb begin
        and_t = '1;
        or_t = '0;
        for (int i = 0; i < NV; i++) begin
            if (var_hit[i]) begin
                and_t = and_t & var_type[i];
                or_t = or_t | var_type[i];
            end
        end
        if (and_t == or_t) begin
            merged_type = and_t;
        end else if (and_t == type_range_pkg::TYPE_WRITE_THROUGH
            && or_t == type_range_pkg::TYPE_WRITE_BACK) begin
            merged_type = type_range_pkg::TYPE_WRITE_THROUGH;
        end else begin
            merged_type = type_range_pkg::TYPE_UNCACHED;
        end
    end
    wire logic var_any = |var_hit;

    // ************************************************************
    // Precedence and result
    // ************************************************************
    // Global off beats all; fixed beats variable; default is the fallback
    wire logic [TW-1:0] next_type = !global_en ? type_range_pkg::TYPE_UNCACHED
        : fixed_hit ? fixed_type
        : var_any ? merged_type
        : def_type;

    logic res_valid;
    logic [TW-1:0] res_type;
    // Fixed one-cycle latency; register writes never stall it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_type <= type_range_pkg::TYPE_UNCACHED;
        end else begin
            res_valid <= lookup_req.valid;
            res_type <= next_type;
        end
    end
    assign lookup_rsp = '{valid: res_valid, mem_type: res_type};

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_bad_def_write;
        reg_req.wr && is_def && def_bad;
    endsequence
    sequence s_fault_kept_out;
        fault && $stable(default_type_control);
    endsequence

    a_def_type_fault: assert property (s_bad_def_write |=> s_fault_kept_out)
        else $error("illegal default write not refused");
    a_def_rsvd_fault: assert property (
        reg_req.wr && is_def && ((wdata & type_range_pkg::DEF_RSVD) != '0) |=> fault)
        else $error("reserved default bits did not fault");
    a_var_rsvd_fault: assert property (
        reg_req.wr && is_var && var_is_mask && mask_bad
        |=> fault && $stable(variable_range_mask[$past(var_slot)]))
        else $error("reserved mask bits did not fault");
    a_global_off_uc: assert property (
        lookup_req.valid && !global_en
        |=> lookup_rsp.valid && lookup_rsp.mem_type == type_range_pkg::TYPE_UNCACHED)
        else $error("disabled lookup not uncached");
    a_fixed_wins: assert property (
        lookup_req.valid && global_en && fixed_on && in_first_mb && var_any
        |=> lookup_rsp.mem_type == $past(fixed_type))
        else $error("fixed range lost to variable range");
    a_default_fill: assert property (
        lookup_req.valid && global_en && !fixed_hit && var_hit == '0
        |=> lookup_rsp.mem_type == $past(def_type))
        else $error("unmapped address not default type");
    a_uc_overlap: assert property (
        lookup_req.valid && global_en && !fixed_hit && var_hit[0] && var_hit[1]
        && var_type[0] == type_range_pkg::TYPE_UNCACHED
        |=> lookup_rsp.mem_type == type_range_pkg::TYPE_UNCACHED)
        else $error("uncached overlap not uncached");
    a_lookup_latency: assert property (
        lookup_req.valid |=> lookup_rsp.valid ##1 (lookup_rsp.valid == $past(lookup_req.valid)))
        else $error("lookup answer latency wrong");
    a_good_write_kept: assert property (
        reg_req.wr && is_def && !def_bad && !reg_req.rd
        |=> !fault && (fixed_on == $past(wdata[type_range_pkg::FIXED_ON_BIT])))
        else $error("legal default write not stored");
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n |=> !global_en && variable_range_mask[0][type_range_pkg::VALID_BIT] == 1'b0)
        else $error("reset left enable or valid set");
endmodule // type_range_register_unit
`default_nettype wire

// file: verif/core_lookup_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Core access path issuing type lookups
// ************************************************************
module core_lookup_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request from the bench
    input wire logic go,
    input wire logic [35:0] go_addr,
    // Lookup port of the unit
    output type_range_pkg::lookup_req_t lookup_req,
    input wire type_range_pkg::lookup_rsp_t lookup_rsp,
    // Sticky flag for an answer with a reserved code
    output logic bad_type
);
    logic [7:0] t;

    assign t = lookup_rsp.mem_type;

    // One request per go pulse; idle address wiggles so a stale value never looks valid
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lookup_req <= '0;
        end else if (go) begin
            lookup_req <= '{1'b1, go_addr};
        end else begin
            lookup_req.valid <= 1'b0;
            lookup_req.addr <= ~lookup_req.addr;
        end
    end

    // Only the five defined codes may come back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bad_type <= 1'b0;
        end else if (lookup_rsp.valid && !(t == 8'h00 || t == 8'h01 || t == 8'h04
            || t == 8'h05 || t == 8'h06)) begin
            bad_type <= 1'b1;
        end
    end
endmodule // core_lookup_model
`default_nettype wire

// file: verif/memory_type_range_lookup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module memory_type_range_lookup_tb;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic go;
    logic [35:0] ga;
    logic bad_type;
    type_range_pkg::reg_req_t rq;
    type_range_pkg::reg_rsp_t rsp;
    type_range_pkg::lookup_req_t lq;
    type_range_pkg::lookup_rsp_t lr;
    logic [63:0] def_sh;
    logic [63:0] fix_sh [11];
    logic [63:0] var_sh [16];
    logic [31:0] seed;
    logic [7:0] legal [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
    int rsv_bits [5] = '{8, 9, 12, 35, 63};
    int base_bits [4] = '{8, 11, 36, 63};
    int mask_bits [4] = '{0, 10, 36, 63};
    logic [63:0] def_vals [4] = '{64'hc06, 64'h806, 64'h406, 64'h800};
    logic [19:0] edge_addrs [5] = '{20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000, 20'hfffff};
    logic [63:0] d;
    logic [35:0] a;
    int errors = 0;
    int samples_checked = 0;

    always #25 ref_clk = ~ref_clk;

    type_range_register_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(rq),
        .reg_rsp(rsp), .lookup_req(lq), .lookup_rsp(lr));
    core_lookup_model partner (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .go_addr(ga),
        .lookup_req(lq), .lookup_rsp(lr), .bad_type(bad_type));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Expected type from the shadow copies
    function automatic logic [7:0] exp_type(input logic [35:0] x);
        logic [35:0] mk;
        logic [7:0] acc;
        logic hit;
        int r;
        int b;
        hit = 1'b0;
        acc = 8'h00;
        if (!def_sh[11]) return 8'h00;
        if (def_sh[10] && x < 36'h100000) begin
            if (x < 36'h80000) begin
                r = 0;
                b = x[18:16];
            end else if (x < 36'hc0000) begin
                r = 1 + x[17];
                b = x[16:14];
            end else begin
                r = 3 + x[17:15];
                b = x[14:12];
            end
            return fix_sh[r][b*8 +: 8];
        end
        for (int n = 0; n < 8; n++) begin
            mk = {var_sh[2*n+1][35:12], 12'h000};
            if (var_sh[2*n+1][11] && ((x & mk) == ({var_sh[2*n][35:12], 12'h000} & mk))) begin
                if (!hit || acc == var_sh[2*n][7:0]) acc = var_sh[2*n][7:0];
                else if ((acc == 8'h04 || acc == 8'h06) && (var_sh[2*n][7:0] == 8'h04
                    || var_sh[2*n][7:0] == 8'h06)) acc = 8'h04;
                else acc = 8'h00;
                hit = 1'b1;
            end
        end
        return hit ? acc : def_sh[7:0];
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        def_sh = '0;
        foreach (fix_sh[i]) fix_sh[i] = '0;
        foreach (var_sh[i]) var_sh[i] = '0;
    endtask

    // Register write; shadow follows only when no fault is expected
    task automatic wr(input logic [5:0] i, input logic [63:0] v, input logic f);
        @(posedge ref_clk);
        rq <= '{1'b1, 1'b0, i, v};
        @(posedge ref_clk);
        rq.wr <= 1'b0;
        #1;
        chk("write fault", {63'h0, f}, {63'h0, rsp.fault});
        if (!f && i == 6'h00) def_sh = v;
        else if (!f && i <= 6'h0b) fix_sh[i-1] = v;
        else if (!f) var_sh[i-16] = v;
    endtask

    task automatic rd(input logic [5:0] i, input logic [63:0] e, input logic f);
        @(posedge ref_clk);
        rq <= '{1'b0, 1'b1, i, 64'h0};
        @(posedge ref_clk);
        rq.rd <= 1'b0;
        #1;
        if (!f) chk("read valid", 64'h1, {63'h0, rsp.rd_valid});
        chk("read data", e, rsp.rd_data);
        chk("read fault", {63'h0, f}, {63'h0, rsp.fault});
    endtask

    // Lookup through the partner, answer awaited under a bound
    task automatic look(input logic [35:0] x);
        int k;
        @(posedge ref_clk);
        go <= 1'b1;
        ga <= x;
        @(posedge ref_clk);
        go <= 1'b0;
        for (k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            #1;
            if (lr.valid === 1'b1) break;
        end
        if (k == 4) begin
            errors++;
            test_done();
        end
        chk("lookup latency", 64'h0, 64'(k));
        chk("lookup type", {56'h0, exp_type(x)}, {56'h0, lr.mem_type});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rq = '0;
        go = 1'b0;
        ga = '0;
        seed = 32'he9e9;
        do_reset();
        rd(6'h00, 64'h0, 1'b0);
        rd(6'h11, 64'h0, 1'b0);
        look(36'h00_0004_0000);
        rd(6'h0c, 64'h0, 1'b1);
        wr(6'h0c, 64'h0, 1'b1);
        for (int t = 0; t < 8; t++) wr(6'h00, 64'h0c00 | t, !(t inside {0, 1, 4, 5, 6}));
        foreach (rsv_bits[j]) wr(6'h00, 64'h0c06 | (64'h1 << rsv_bits[j]), 1'b1);
        foreach (base_bits[j]) begin
            wr(6'h10, 64'h6 | (64'h1 << base_bits[j]), 1'b1);
            wr(6'h11, 64'h800 | (64'h1 << mask_bits[j]), 1'b1);
        end
        wr(6'h10, 64'h2, 1'b1);
        wr(6'h01, 64'h0000_0300_0000_0000, 1'b1);
        for (int r = 0; r < 11; r++) begin
            for (int b = 0; b < 8; b++) d[b*8 +: 8] = legal[rnd() % 5];
            wr(6'h01 + r[5:0], d, 1'b0);
            rd(6'h01 + r[5:0], d, 1'b0);
        end
        foreach (def_vals[p]) begin
            for (int n = 0; n < 8; n++) begin
                wr(6'h10 + 2 * n, {40'h0, 12'(rnd()), 4'h0, legal[rnd() % 5]}, 1'b0);
                d = {28'h0, 24'hffffff << (rnd() % 12), 12'h000} | {52'h0, rnd() % 4 != 0, 11'h0};
                if (n == 7) d[35:12] = 24'(rnd());
                wr(6'h11 + 2 * n, d, 1'b0);
            end
            wr(6'h00, def_vals[p], 1'b0);
            foreach (edge_addrs[j]) look({16'h0, edge_addrs[j]});
            look(36'h00_0010_0000);
            for (int k = 0; k < 60; k++) begin
                d[31:0] = rnd();
                a = {d[11:0] & {12{d[7] & d[6] & d[5]}}, d[31:8]};
                if (d[0]) a[35:20] = '0;
                look(a);
            end
        end
        do_reset();
        rd(6'h00, 64'h0, 1'b0);
        rd(6'h1f, 64'h0, 1'b0);
        look(36'h00_0000_1000);
        chk("legal type", 64'h0, {63'h0, bad_type});
        test_done();
    end
endmodule // memory_type_range_lookup_tb
`default_nettype wire
